/* tbm_regs.svh */
`ifndef TBM_REGS_SVH
`define TBM_REGS_SVH

`define TBM_ADDR_W        8
`define TBM_DATA_W        16
`define TBM_NCH           6
`define TBM_NCH_A         3
`define TBM_MODE_W        8

`define TBM_OFS_START_A   8'h00
`define TBM_OFS_START_B   8'h04
`define TBM_OFS_IRQ_STAT  8'h08
`define TBM_OFS_IRQ_MASK  8'h0C
`define TBM_OFS_CH_BASE   8'h10
`define TBM_CH_STRIDE     8'h08
`define TBM_OFS_MODE      8'h00
`define TBM_OFS_CNT       8'h04

`define TBM_MR_OP_LO      0
`define TBM_MR_OP_HI      1
`define TBM_MR_SEL0       2
`define TBM_MR_SEL1       3
`define TBM_MR_CFG2       4
`define TBM_MR_OVF        5
`define TBM_MR_SRC_LO     6
`define TBM_MR_SRC_HI     7
`define TBM_MR_WMASK      8'hDF

`define TBM_MODE_RST      8'h00
`define TBM_CNT_RST       16'h0000
`define TBM_CNT_ZERO      16'h0000
`define TBM_CNT_ONE       16'h0001
`define TBM_ALL_ONES      16'hFFFF

`define TBM_PRE_W         6
`define TBM_PRE_RST       6'h00
`define TBM_NSRC          4
`define TBM_DIV8_MASK     6'h07
`define TBM_DIV32_MASK    6'h1F
`define TBM_DIV64_MASK    6'h3F

`endif

/* tbm_pkg.sv */
`include "tbm_regs.svh"

package tbm_pkg;
  typedef enum logic [1:0] {
    TBM_OP_TIMER,
    TBM_OP_EVENT,
    TBM_OP_MEAS,
    TBM_OP_RSVD
  } tbm_opmode_t;
endpackage

/* tbm_sync.sv */
`timescale 1ns/1ps
`include "tbm_regs.svh"

module tbm_sync (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Level accepted only once the last two stages agree
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lvl_reg <= 1'b0;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (s2_reg == s3_reg && s3_reg != lvl_reg) begin
        lvl_reg <= s3_reg;
        rise_o  <= s3_reg;
        fall_o  <= ~s3_reg;
      end
    end
  end
endmodule

/* tbm_prescaler.sv */
`timescale 1ns/1ps
`include "tbm_regs.svh"

module tbm_prescaler (
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  output logic [`TBM_NSRC-1:0]      tick_o
);
  logic [`TBM_PRE_W-1:0] div_reg;

  // Free running so every channel sees the same tick phase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_reg <= `TBM_PRE_RST;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_comb begin
    tick_o[0] = 1'b1;
    tick_o[1] = (div_reg & `TBM_DIV8_MASK) == `TBM_PRE_RST;
    tick_o[2] = (div_reg & `TBM_DIV32_MASK) == `TBM_PRE_RST;
    tick_o[3] = (div_reg & `TBM_DIV64_MASK) == `TBM_PRE_RST;
  end
endmodule

/* tbm_timer_b.sv */
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`include "tbm_regs.svh"

// Contract
// - Six independent channels 0..5, start bits split over two start registers.
// - Channels idle after reset; counting begins only when start bit written 1.
// - Counter read returns live count while running, last capture in measurement mode; FFFFh if read during reload.
// - Counter written while stopped reads back that value until counting starts.
// - Measurement mode raises interrupt on effective edge and on counter overflow.
// - Measurement mode keeps readable overflow flag in mode register, set on overflow.
// - Overflow flag clears on mode write while running, after one tick since set.
// - First effective edge after start loads indeterminate capture, no interrupt.
// - Count indeterminate at start; overflow may flag before first edge.
// - Width measurement measures high and low back to back, no level indication.
module tbm_timer_b
  import tbm_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  input  wire logic [`TBM_ADDR_W-1:0] addr_i,
  input  wire logic [`TBM_DATA_W-1:0] wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [`TBM_DATA_W-1:0] rdata_o,
  input  wire logic [`TBM_NCH-1:0]    pulse_i,
  output logic      [`TBM_NCH-1:0]    running_o,
  output logic                        irq_o
);
  logic [`TBM_NSRC-1:0]   src_tick;
  logic [`TBM_NCH-1:0]    rise;
  logic [`TBM_NCH-1:0]    fall;

  logic [`TBM_NCH-1:0]    start_reg;
  logic [`TBM_NCH-1:0]    start_d_reg;
  logic [`TBM_NCH-1:0]    irq_stat_reg;
  logic [`TBM_NCH-1:0]    irq_mask_reg;
  logic [`TBM_DATA_W-1:0] rdata_next;

  logic [`TBM_MODE_W-1:0] mode_reg   [`TBM_NCH];
  logic [`TBM_DATA_W-1:0] cnt_reg    [`TBM_NCH];
  logic [`TBM_DATA_W-1:0] reload_reg [`TBM_NCH];
  logic [`TBM_NCH-1:0]    ovf_reg;
  logic [`TBM_NCH-1:0]    ovf_aged_reg;
  logic [`TBM_NCH-1:0]    first_seen_reg;

  logic [`TBM_NCH-1:0]    sel_mode;
  logic [`TBM_NCH-1:0]    sel_cnt;
  logic [`TBM_NCH-1:0]    reload_now;
  logic [`TBM_NCH-1:0]    irq_evt;

  tbm_prescaler u_pre (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .tick_o (src_tick)
  );

  // Start bits; channels 0..2 in register A, 3..5 in register B
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start_reg   <= '0;
      start_d_reg <= '0;
    end else begin
      start_d_reg <= start_reg;
      if (wr_i && addr_i == `TBM_OFS_START_A) begin
        start_reg[`TBM_NCH_A-1:0] <= wdata_i[`TBM_NCH_A-1:0];
      end
      if (wr_i && addr_i == `TBM_OFS_START_B) begin
        start_reg[`TBM_NCH-1:`TBM_NCH_A] <= wdata_i[`TBM_NCH-`TBM_NCH_A-1:0];
      end
    end
  end

  assign running_o = start_reg;

  genvar ch;
  generate
    for (ch = 0; ch < `TBM_NCH; ch++) begin : g_ch
      localparam logic [`TBM_ADDR_W-1:0] MODE_ADDR =
        `TBM_ADDR_W'(`TBM_OFS_CH_BASE + ch * `TBM_CH_STRIDE + `TBM_OFS_MODE);
      localparam logic [`TBM_ADDR_W-1:0] CNT_ADDR =
        `TBM_ADDR_W'(`TBM_OFS_CH_BASE + ch * `TBM_CH_STRIDE + `TBM_OFS_CNT);

      tbm_opmode_t op;
      logic        tick;
      logic        eff_edge;
      logic        step;
      logic        run;
      logic        start_rise;
      logic        mode_wr;
      logic        cnt_wr;
      logic        ovf_set;
      logic        ovf_clr;
      logic        capture;

      tbm_sync u_sync (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .pin_i  (pulse_i[ch]),
        .rise_o (rise[ch]),
        .fall_o (fall[ch])
      );

      assign sel_mode[ch] = addr_i == MODE_ADDR;
      assign sel_cnt[ch]  = addr_i == CNT_ADDR;
      assign mode_wr      = wr_i && sel_mode[ch];
      assign cnt_wr       = wr_i && sel_cnt[ch];

      always_comb begin
        op   = tbm_opmode_t'(mode_reg[ch][`TBM_MR_OP_HI:`TBM_MR_OP_LO]);
        tick = src_tick[mode_reg[ch][`TBM_MR_SRC_HI:`TBM_MR_SRC_LO]];
        // Both edges for width measurement, so high and low widths alternate
        if (mode_reg[ch][`TBM_MR_SEL1]) begin
          eff_edge = rise[ch] | fall[ch];
        end else if (mode_reg[ch][`TBM_MR_SEL0]) begin
          eff_edge = rise[ch];
        end else begin
          eff_edge = fall[ch];
        end
        run        = start_reg[ch] & start_d_reg[ch];
        start_rise = start_reg[ch] & ~start_d_reg[ch];
        step       = (op == TBM_OP_EVENT) ? eff_edge : tick;
        reload_now[ch] = run && op != TBM_OP_MEAS && step &&
                         cnt_reg[ch] == `TBM_CNT_ZERO;
        ovf_set    = run && op == TBM_OP_MEAS && tick &&
                     cnt_reg[ch] == `TBM_ALL_ONES;
        capture    = run && op == TBM_OP_MEAS && eff_edge;
        ovf_clr    = mode_wr && start_reg[ch] && ovf_aged_reg[ch];
        // First capture after start is suppressed
        irq_evt[ch] = reload_now[ch] | ovf_set |
                      (capture & first_seen_reg[ch]);
      end

      // Mode fields; overflow bit is held separately and not writable
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          mode_reg[ch] <= `TBM_MODE_RST;
        end else if (mode_wr) begin
          mode_reg[ch] <= wdata_i[`TBM_MODE_W-1:0] & `TBM_MR_WMASK;
        end
      end

      // Set wins over a clear in the same cycle
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          ovf_reg[ch]      <= 1'b0;
          ovf_aged_reg[ch] <= 1'b0;
        end else begin
          ovf_reg[ch] <= ovf_set | (ovf_reg[ch] & ~ovf_clr);
          if (ovf_set) begin
            ovf_aged_reg[ch] <= 1'b0;
          end else if (ovf_reg[ch] && tick) begin
            ovf_aged_reg[ch] <= 1'b1;
          end
        end
      end

      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          cnt_reg[ch]        <= `TBM_CNT_RST;
          reload_reg[ch]     <= `TBM_CNT_RST;
          first_seen_reg[ch] <= 1'b0;
        end else if (!start_reg[ch]) begin
          first_seen_reg[ch] <= 1'b0;
          if (cnt_wr) begin
            cnt_reg[ch]    <= wdata_i;
            reload_reg[ch] <= wdata_i;
          end
        end else if (start_rise) begin
          first_seen_reg[ch] <= 1'b0;
          // Measurement starts from whatever the counter holds
          if (op != TBM_OP_MEAS) begin
            cnt_reg[ch] <= reload_reg[ch];
          end
        end else if (op == TBM_OP_MEAS) begin
          if (capture) begin
            // First capture is a stale count, treat as unknown
            reload_reg[ch]     <= cnt_reg[ch];
            cnt_reg[ch]        <= `TBM_CNT_ZERO;
            first_seen_reg[ch] <= 1'b1;
          end else if (tick) begin
            cnt_reg[ch] <= cnt_reg[ch] + `TBM_CNT_ONE;
          end
        end else begin
          if (cnt_wr) begin
            reload_reg[ch] <= wdata_i;
          end
          if (reload_now[ch]) begin
            cnt_reg[ch] <= reload_reg[ch];
          end else if (step) begin
            cnt_reg[ch] <= cnt_reg[ch] - `TBM_CNT_ONE;
          end
        end
      end
    end
  endgenerate

  // Interrupt status, write one to clear, new events win
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      if (wr_i && addr_i == `TBM_OFS_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~wdata_i[`TBM_NCH-1:0]) | irq_evt;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_evt;
      end
      if (wr_i && addr_i == `TBM_OFS_IRQ_MASK) begin
        irq_mask_reg <= wdata_i[`TBM_NCH-1:0];
      end
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  always_comb begin
    rdata_next = '0;
    if (addr_i == `TBM_OFS_START_A) begin
      rdata_next[`TBM_NCH_A-1:0] = start_reg[`TBM_NCH_A-1:0];
    end else if (addr_i == `TBM_OFS_START_B) begin
      rdata_next[`TBM_NCH-`TBM_NCH_A-1:0] = start_reg[`TBM_NCH-1:`TBM_NCH_A];
    end else if (addr_i == `TBM_OFS_IRQ_STAT) begin
      rdata_next[`TBM_NCH-1:0] = irq_stat_reg;
    end else if (addr_i == `TBM_OFS_IRQ_MASK) begin
      rdata_next[`TBM_NCH-1:0] = irq_mask_reg;
    end
    for (int i = 0; i < `TBM_NCH; i++) begin
      if (sel_mode[i]) begin
        rdata_next[`TBM_MODE_W-1:0] = mode_reg[i];
        rdata_next[`TBM_MR_OVF]     = ovf_reg[i];
      end else if (sel_cnt[i]) begin
        if (reload_now[i]) begin
          rdata_next = `TBM_ALL_ONES;
        end else if (start_reg[i] &&
                     mode_reg[i][`TBM_MR_OP_HI:`TBM_MR_OP_LO] == TBM_OP_MEAS) begin
          rdata_next = reload_reg[i];
        end else begin
          rdata_next = cnt_reg[i];
        end
      end
    end
  end

  // Unmapped reads return zero
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= rdata_next;
    end else begin
      rdata_o <= '0;
    end
  end
endmodule

/* tbm_pulse_src.sv */
`timescale 1ns/1ps
module tbm_pulse_src #(parameter int HALF = 20) (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [5:0] en_i,
  output logic      [5:0] pulse_o
);
  int cnt;
  // Driven pins hold their level while disabled
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 0;
      pulse_o <= 6'h00;
    end else begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) pulse_o <= pulse_o ^ en_i;
    end
  end
endmodule

/* tbm_timer_b_assertions.sv */
`timescale 1ns/1ps
module tbm_timer_b_chk (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic [5:0]  pulse_i,
  input wire logic [5:0]  running_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  chk_idle_at_release: assert property ($rose(rstn_i) |-> !running_o && !irq_o)
    else $error("channel active after reset");
  chk_start_a_write: assert property (wr_i && addr_i == 8'h00
    |=> running_o[2:0] == $past(wdata_i[2:0]))
    else $error("start A write not applied");
  chk_start_b_write: assert property (wr_i && addr_i == 8'h04
    |=> running_o[5:3] == $past(wdata_i[2:0]))
    else $error("start B write not applied");
  chk_run_only_write: assert property (!wr_i |=> $stable(running_o))
    else $error("start bits moved without write");
  chk_start_readback: assert property (rd_i && addr_i == 8'h00
    |=> rdata_o == {13'h0000, $past(running_o[2:0])})
    else $error("start A readback wrong");
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside read");
  chk_unmapped_zero: assert property (rd_i && addr_i == 8'hFF |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  chk_mask_off_quiet: assert property (wr_i && addr_i == 8'h0C && wdata_i[5:0] == 6'h00
    |=> !irq_o)
    else $error("interrupt with all masked");
  chk_stopped_read: assert property ((wr_i && addr_i == 8'h14 && !running_o[0]) ##2
    (rd_i && addr_i == 8'h14 && !running_o[0]) |=> rdata_o == $past(wdata_i, 3))
    else $error("stopped counter readback wrong");
  cover property (wr_i && addr_i == 8'h00 && wdata_i[0]);
  cover property ($rose(irq_o));
  cover property (rd_i ##1 rdata_o == 16'hFFFF);
endmodule
bind tbm_timer_b tbm_timer_b_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pulse_i(pulse_i),
  .running_o(running_o), .irq_o(irq_o));

/* tbm_testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic [5:0]  pulse_i;
  logic [5:0]  running_o;
  logic [5:0]  pen = 6'h00;
  logic        irq_o;
  logic [15:0] d;
  logic [15:0] e;
  logic        seen;
  logic [31:0] seed = 32'h52941822;
  int          mismatches = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #4 clk_i = ~clk_i;
  tbm_timer_b dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pulse_i(pulse_i),
    .running_o(running_o), .irq_o(irq_o));
  tbm_pulse_src #(.HALF(20)) src (.clk_i(clk_i), .rstn_i(rstn_i), .en_i(pen),
    .pulse_o(pulse_i));
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic [15:0] period(int h);
    return 16'(2 * h);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_in(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    num_checks++;
    if (!(got >= lo && got <= hi)) begin
      mismatches++;
      $display("BAD %0t got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int a = 0; a < 64; a += 4) begin
      rd(8'(a), e);
      chk(e, 16'h0000);
    end
    rd(8'hFF, e);
    chk(e, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      d = rnd();
      wr(8'h14 + 8'(8 * i), d);
      rd(8'h14 + 8'(8 * i), e);
      chk(e, d);
    end
    d = rnd();
    wr(8'h00, {13'h0000, d[2:0]});
    wr(8'h04, {13'h0000, d[5:3]});
    #1 chk({10'h000, running_o}, {10'h000, d[5:0]});
    rd(8'h04, e);
    chk(e, {13'h0000, d[5:3]});
    wr(8'h00, 16'h0000);
    wr(8'h04, 16'h0000);
    wr(8'h08, 16'h003F);
    rd(8'h08, e);
    chk(e, 16'h0000);
    $display("test start done");
    // Timer, reload 4, interrupt held back by mask first
    wr(8'h14, 16'h0004);
    wr(8'h10, 16'h0000);
    wr(8'h0C, 16'h0000);
    wr(8'h00, 16'h0001);
    repeat (12) @(posedge clk_i);
    #1 chk({15'h0000, irq_o}, 16'h0000);
    rd(8'h08, e);
    chk(e, 16'h0001);
    wr(8'h0C, 16'h0001);
    #1 chk({15'h0000, irq_o}, 16'h0001);
    seen = 1'b0;
    for (int i = 0; i < 30; i++) begin
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= 8'h14;
      #1 if (i > 1 && rdata_o !== 16'hFFFF) chk_in(rdata_o, 16'h0000, 16'h0004);
      seen |= (i > 1 && rdata_o === 16'hFFFF);
    end
    @(posedge clk_i);
    rd_i <= 1'b0;
    chk({15'h0000, seen}, 16'h0001);
    wr(8'h00, 16'h0000);
    wr(8'h08, 16'h0001);
    #1 chk({15'h0000, irq_o}, 16'h0000);
    $display("test timer done");
    // Period measurement, rising edges, channel 1
    wr(8'h1C, 16'h0000);
    wr(8'h18, 16'h0006);
    wr(8'h0C, 16'h0002);
    wr(8'h00, 16'h0002);
    pen <= 6'h02;
    @(posedge pulse_i[1]);
    repeat (8) @(posedge clk_i);
    rd(8'h08, e);
    chk(e, 16'h0000);
    @(posedge pulse_i[1]);
    repeat (8) @(posedge clk_i);
    rd(8'h08, e);
    chk(e, 16'h0002);
    rd(8'h1C, e);
    chk_in(e, period(20) - 16'h0001, period(20) + 16'h0001);
    wr(8'h00, 16'h0000);
    pen <= 6'h00;
    wr(8'h1C, 16'hFFF0);
    wr(8'h08, 16'h0002);
    wr(8'h00, 16'h0002);
    repeat (30) @(posedge clk_i);
    rd(8'h18, e);
    chk(e, 16'h0026);
    rd(8'h08, e);
    chk(e, 16'h0002);
    wr(8'h18, 16'h0006);
    rd(8'h18, e);
    chk(e, 16'h0006);
    wr(8'h00, 16'h0000);
    $display("test measure done");
    // Event counter, rising edges on channel 2, underflow on third edge
    wr(8'h08, 16'h003F);
    wr(8'h24, 16'h0002);
    wr(8'h20, 16'h0005);
    wr(8'h00, 16'h0004);
    pen <= 6'h04;
    repeat (3) @(posedge pulse_i[2]);
    repeat (8) @(posedge clk_i);
    rd(8'h08, e);
    chk(e, 16'h0004);
    wr(8'h00, 16'h0000);
    pen <= 6'h00;
    $display("test event done");
    close_out();
  end
endmodule
